// *** src/status_paging_stack.sv ***
// module: flag register, program page selection and return stack control
// Operation
// - flag register writable like any file register
// - flag-affecting instruction overrides written zero/dc/carry
// - timeout and powerdown flags not writable
// - clear-file zeroes upper bits, sets zero
// - page field selects one of four pages
// - timeout set by powerup/clear_watchdog_instr/sleep, cleared by timeout
// - increment crosses pages without touching page field
// - jump/call/pcl write take page field bits
// - reset loads program counter with reset vector
// - reset clears page field
// - two-level return stack, full pc width
// - call shifts level1 down, pushes pc plus one
// - return loads pc from level1, level2 moves up
// - repeated returns keep level2 address
// - return loads working register with literal
`timescale 1ns/100ps
module status_paging_stack #(
  parameter int PC_WIDTH = flow_pkg::PC_WIDTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic power_up_in,
  input wire flow_pkg::file_write_t file_in,
  input wire flow_pkg::alu_op_t alu_op_in,
  input wire logic [7:0] alu_a_in,
  input wire logic [7:0] alu_b_in,
  input wire flow_pkg::flow_op_t flow_op_in,
  input wire logic [8:0] target_in,
  input wire logic [7:0] literal_in,
  input wire flow_pkg::power_event_t power_in,
  input wire logic rd_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic [7:0] flags_out,
  output logic [7:0] alu_result_out,
  output logic [PC_WIDTH-1:0] pc_out,
  output logic [7:0] working_out
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] flags;
    logic [PC_WIDTH-1:0] pc;
    logic [7:0] working;
    logic [7:0] rd_data;
    logic [7:0] alu_result;
  } core_state_t;
  core_state_t state;
  core_state_t next_state;
  logic [7:0] result;
  logic zero;
  logic digit_carry;
  logic carry;
  logic [PC_WIDTH-1:0] stack_top;
  logic [PC_WIDTH-1:0] page_target;
  logic push;
  logic pop;

  // ==========================================================
  // alu and stack
  alu_flags u_alu (
    .op_in(alu_op_in),
    .a_in(alu_a_in),
    .b_in(alu_b_in),
    .carry_in(state.flags[flow_pkg::CARRY_BIT]),
    .result_out(result),
    .zero_out(zero),
    .digit_carry_out(digit_carry),
    .carry_out(carry)
  );

  assign push = (flow_op_in == flow_pkg::FLOW_CALL);
  assign pop = (flow_op_in == flow_pkg::FLOW_RETURN);

  return_stack #(
    .WIDTH(PC_WIDTH)
  ) u_stack (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .push_in(push),
    .pop_in(pop),
    .push_addr_in(PC_WIDTH'(state.pc + 1'b1)),
    .top_out(stack_top)
  );

  // page base from page field plus low target bits
  assign page_target = PC_WIDTH'({state.flags[flow_pkg::PAGE_HI_BIT:flow_pkg::PAGE_LO_BIT], target_in});

  // ==========================================================
  // next state
  always_comb begin
    logic alu_sets;
    alu_sets = (alu_op_in != flow_pkg::ALU_NONE);
    next_state = state;
    next_state.alu_result = result;
    next_state.rd_data = (rd_in && rd_addr_in == flow_pkg::FLAGS_ADDR) ? state.flags : 8'h00;
    if (file_in.write && file_in.addr == flow_pkg::FLAGS_ADDR) begin
      if (file_in.clear_file) begin
        next_state.flags[7:5] = 3'h0;
      end else begin
        next_state.flags[7:5] = file_in.data[7:5];
        if (!alu_sets) begin
          next_state.flags[2:0] = file_in.data[2:0];
        end
      end
      // timeout and powerdown bits keep their value
    end
    if (file_in.write && file_in.clear_file) begin
      next_state.flags[flow_pkg::ZERO_BIT] = 1'b1;
    end
    if (alu_sets) begin
      next_state.flags[flow_pkg::ZERO_BIT] = zero;
      if (alu_op_in == flow_pkg::ALU_ADD || alu_op_in == flow_pkg::ALU_SUB) begin
        next_state.flags[flow_pkg::DIGIT_CARRY_BIT] = digit_carry;
      end
      if (alu_op_in != flow_pkg::ALU_LOGIC) begin
        next_state.flags[flow_pkg::CARRY_BIT] = carry;
      end
    end
    if (power_up_in) begin
      next_state.flags[flow_pkg::TIMEOUT_BIT] = 1'b1;
      next_state.flags[flow_pkg::POWERDOWN_BIT] = 1'b1;
    end else if (power_in.watchdog_timeout) begin
      next_state.flags[flow_pkg::TIMEOUT_BIT] = 1'b0;
    end else if (power_in.clear_watchdog) begin
      next_state.flags[flow_pkg::TIMEOUT_BIT] = 1'b1;
      next_state.flags[flow_pkg::POWERDOWN_BIT] = 1'b1;
    end else if (power_in.sleep) begin
      next_state.flags[flow_pkg::TIMEOUT_BIT] = 1'b1;
      next_state.flags[flow_pkg::POWERDOWN_BIT] = 1'b0;
    end
    unique case (flow_op_in)
      flow_pkg::FLOW_JUMP, flow_pkg::FLOW_CALL: begin
        next_state.pc = page_target;
      end
      flow_pkg::FLOW_PCL_WRITE: begin
        next_state.pc = PC_WIDTH'({state.flags[flow_pkg::PAGE_HI_BIT:flow_pkg::PAGE_LO_BIT], 1'b0,
          file_in.data});
      end
      flow_pkg::FLOW_RETURN: begin
        next_state.pc = stack_top;
        next_state.working = literal_in;
      end
      default: begin
        next_state.pc = PC_WIDTH'(state.pc + 1'b1);
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state.pc <= flow_pkg::RESET_VECTOR;
      state.flags <= flow_pkg::FLAGS_RESET;
      state.working <= 8'h00;
      state.rd_data <= 8'h00;
      state.alu_result <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data_out = state.rd_data;
  assign flags_out = state.flags;
  assign alu_result_out = state.alu_result;
  assign pc_out = state.pc;
  assign working_out = state.working;

  // ==========================================================
  // checks
  sequence call_s;
    flow_op_in == flow_pkg::FLOW_CALL;
  endsequence
  sequence return_s;
    flow_op_in == flow_pkg::FLOW_RETURN;
  endsequence

  reset_vector_a: assert property (@(posedge sys_clk_in) rst_in |=> pc_out == flow_pkg::RESET_VECTOR)
    else $error("pc not at reset vector");
  reset_page_a: assert property (@(posedge sys_clk_in) rst_in |=> flags_out[6:5] == 2'b00)
    else $error("page field not cleared");
  ro_flags_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (file_in.write && file_in.addr == flow_pkg::FLAGS_ADDR && power_in == '0) |=> $stable(flags_out[4:3]))
    else $error("timeout or powerdown written");
  clear_file_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (file_in.write && file_in.clear_file && file_in.addr == flow_pkg::FLAGS_ADDR && alu_op_in == flow_pkg::ALU_NONE)
    |=> flags_out[7:5] == 3'h0 && flags_out[2])
    else $error("clear file wrong");
  sleep_flags_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (power_in.sleep && !power_in.watchdog_timeout && !power_in.clear_watchdog) |=> flags_out[4:3] == 2'b10)
    else $error("sleep flags wrong");
  wdt_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (power_in.clear_watchdog && !power_in.watchdog_timeout) |=> flags_out[4:3] == 2'b11)
    else $error("clear watchdog flags wrong");
  jump_page_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    flow_op_in == flow_pkg::FLOW_JUMP |=> pc_out[10:9] == $past(flags_out[6:5]))
    else $error("jump page wrong");
  step_page_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (flow_op_in == flow_pkg::FLOW_STEP && !file_in.write) |=> pc_out == PC_WIDTH'($past(pc_out) + 1'b1)
    && $stable(flags_out[6:5]))
    else $error("step crossing wrong");
  call_return_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    call_s ##1 return_s |=> pc_out == PC_WIDTH'($past(pc_out, 2) + 1'b1))
    else $error("return address wrong");
  literal_w_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    return_s |=> working_out == $past(literal_in))
    else $error("literal not loaded");
endmodule : status_paging_stack

// *** src/flow_pkg.sv ***
// package: flag register layout, reset values, page and stack constants
package flow_pkg;
  localparam logic [7:0] FLAGS_ADDR = 8'h03;
  localparam logic [7:0] PCL_ADDR = 8'h02;
  localparam int SPARE_BIT = 7;
  localparam int PAGE_HI_BIT = 6;
  localparam int PAGE_LO_BIT = 5;
  localparam int TIMEOUT_BIT = 4;
  localparam int POWERDOWN_BIT = 3;
  localparam int ZERO_BIT = 2;
  localparam int DIGIT_CARRY_BIT = 1;
  localparam int CARRY_BIT = 0;
  localparam int PC_WIDTH = 11;
  localparam int PAGE_WORD_BITS = 9;
  localparam logic [7:0] FLAGS_RESET = 8'h18;
  localparam logic [PC_WIDTH-1:0] RESET_VECTOR = 11'h7FF;

  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h2,
    ALU_LOGIC = 3'h3,
    ALU_ROT_RIGHT = 3'h4,
    ALU_ROT_LEFT = 3'h5
  } alu_op_t;

  typedef enum logic [2:0] {
    FLOW_STEP = 3'h0,
    FLOW_JUMP = 3'h1,
    FLOW_CALL = 3'h2,
    FLOW_RETURN = 3'h3,
    FLOW_PCL_WRITE = 3'h4
  } flow_op_t;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
    logic clear_file;
  } file_write_t;

  typedef struct packed {
    logic clear_watchdog;
    logic sleep;
    logic watchdog_timeout;
  } power_event_t;
endpackage : flow_pkg

// *** src/alu_flags.sv ***
// module: result and zero, digit-carry, carry of one alu operation
`timescale 1ns/100ps
module alu_flags (
  input wire flow_pkg::alu_op_t op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output logic zero_out,
  output logic digit_carry_out,
  output logic carry_out
);
  logic [8:0] sum;
  logic [4:0] nib;
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    result_out = a_in;
    digit_carry_out = 1'b0;
    carry_out = carry_in;
    unique case (op_in)
      flow_pkg::ALU_ADD: begin
        sum = {1'b0, a_in} + {1'b0, b_in};
        nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
        result_out = sum[7:0];
        digit_carry_out = nib[4];
        carry_out = sum[8];
      end
      flow_pkg::ALU_SUB: begin
        // a minus b as a plus not b plus one, carry set means no borrow
        sum = {1'b0, a_in} + {1'b0, ~b_in} + 9'h001;
        nib = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]} + 5'h01;
        result_out = sum[7:0];
        digit_carry_out = nib[4];
        carry_out = sum[8];
      end
      flow_pkg::ALU_ROT_RIGHT: begin
        result_out = {carry_in, a_in[7:1]};
        carry_out = a_in[0];
      end
      flow_pkg::ALU_ROT_LEFT: begin
        result_out = {a_in[6:0], carry_in};
        carry_out = a_in[7];
      end
      default: begin
        result_out = a_in;
      end
    endcase
    zero_out = (result_out == 8'h00);
  end
endmodule : alu_flags

// *** src/return_stack.sv ***
// module: two-level return address stack
`timescale 1ns/100ps
module return_stack #(
  parameter int WIDTH = flow_pkg::PC_WIDTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [WIDTH-1:0] push_addr_in,
  output logic [WIDTH-1:0] top_out
);
  typedef struct packed {
    logic [WIDTH-1:0] level1;
    logic [WIDTH-1:0] level2;
  } stack_t;
  stack_t state;
  stack_t next_state;
  always_comb begin
    next_state = state;
    if (push_in) begin
      next_state.level2 = state.level1;
      next_state.level1 = push_addr_in;
    end else if (pop_in) begin
      next_state.level1 = state.level2;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign top_out = state.level1;
endmodule : return_stack

// *** tb/core_model.sv ***
// partner model: instruction decoder and alu feeding one instruction per cycle
`timescale 1ns/100ps
module core_model (
  input wire logic sys_clk_in,
  output flow_pkg::file_write_t file_out,
  output flow_pkg::alu_op_t alu_op_out,
  output logic [15:0] ab_out,
  output flow_pkg::flow_op_t flow_out,
  output logic [16:0] tl_out,
  output flow_pkg::power_event_t power_out,
  output logic rd_out
);
  initial begin
    file_out = '0;
    alu_op_out = flow_pkg::ALU_NONE;
    ab_out = 16'h0000;
    flow_out = flow_pkg::FLOW_STEP;
    tl_out = 17'h00000;
    power_out = '0;
    rd_out = 1'b0;
  end
  // every field is set on each edge, so strobes last one cycle
  task automatic ins(input flow_pkg::file_write_t f, input flow_pkg::alu_op_t o, input logic [15:0] ab,
    input flow_pkg::flow_op_t fl, input logic [16:0] tl, input flow_pkg::power_event_t p, input logic r);
    @(posedge sys_clk_in);
    file_out <= f;
    alu_op_out <= o;
    ab_out <= ab;
    flow_out <= fl;
    tl_out <= tl;
    power_out <= p;
    rd_out <= r;
  endtask : ins
endmodule : core_model

// *** tb/tb_top.sv ***
// testbench: flag register, paging and return stack scenarios
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  flow_pkg::file_write_t fw;
  flow_pkg::alu_op_t ao;
  logic [15:0] ab;
  flow_pkg::flow_op_t fo;
  logic [16:0] tl;
  flow_pkg::power_event_t pe;
  logic rd;
  logic [7:0] rd_data, flags, res, w;
  logic [10:0] pc;
  int n_fail = 0;
  int n_checks = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  core_model m (.sys_clk_in(sys_clk_in), .file_out(fw), .alu_op_out(ao), .ab_out(ab), .flow_out(fo),
    .tl_out(tl), .power_out(pe), .rd_out(rd));
  status_paging_stack dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .power_up_in(rst_in), .file_in(fw),
    .alu_op_in(ao), .alu_a_in(ab[15:8]), .alu_b_in(ab[7:0]), .flow_op_in(fo), .target_in(tl[16:8]),
    .literal_in(tl[7:0]), .power_in(pe), .rd_in(rd), .rd_addr_in(fw.addr), .rd_data_out(rd_data),
    .flags_out(flags), .alu_result_out(res), .pc_out(pc), .working_out(w));
  // ==========================================
  // shared tasks
  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // one instruction, then idle; outputs are looked at after the taking edge
  task automatic go(input flow_pkg::file_write_t f, input flow_pkg::alu_op_t o, input logic [15:0] a,
    input flow_pkg::flow_op_t l, input logic [16:0] t, input flow_pkg::power_event_t p, input logic r);
    m.ins(f, o, a, l, t, p, r);
    m.ins('0, flow_pkg::ALU_NONE, 16'h0000, flow_pkg::FLOW_STEP, 17'h00000, '0, 1'b0);
    #1;
  endtask : go
  task automatic wr(input logic [7:0] d);
    go({1'b1, flow_pkg::FLAGS_ADDR, d, 1'b0}, flow_pkg::ALU_NONE, 16'h0000, flow_pkg::FLOW_STEP, 17'h0, '0, 1'b0);
  endtask : wr
  task automatic fl(input flow_pkg::flow_op_t o, input logic [8:0] t, input logic [7:0] l);
    go('0, flow_pkg::ALU_NONE, 16'h0000, o, {t, l}, '0, 1'b0);
  endtask : fl
  task automatic pw(input flow_pkg::power_event_t p, input logic [1:0] e);
    go('0, flow_pkg::ALU_NONE, 16'h0000, flow_pkg::FLOW_STEP, 17'h0, p, 1'b0);
    chk(flags[4:3], e);
  endtask : pw
  task automatic alu(input flow_pkg::alu_op_t o, input logic [15:0] a, input logic [7:0] r, input logic [2:0] e,
    input logic [2:0] k);
    go('0, o, a, flow_pkg::FLOW_STEP, 17'h0, '0, 1'b0);
    chk(res, r);
    chk(flags[2:0] | k, e | k);
  endtask : alu
  // ==========================================
  // scenarios
  task automatic t_reset;
    chk(pc, flow_pkg::RESET_VECTOR);
    go({1'b0, flow_pkg::FLAGS_ADDR, 8'h00, 1'b0}, flow_pkg::ALU_NONE, 16'h0, flow_pkg::FLOW_STEP, 17'h0, '0, 1'b1);
    chk(rd_data, flow_pkg::FLAGS_RESET);
    go({1'b0, 8'h04, 8'h00, 1'b0}, flow_pkg::ALU_NONE, 16'h0, flow_pkg::FLOW_STEP, 17'h0, '0, 1'b1);
    chk(rd_data, 8'h00);
  endtask : t_reset
  task automatic t_write;
    wr(8'h00);
    chk(flags, 8'h18);
    wr(8'hE7);
    chk(flags, 8'hFF);
    go({1'b1, flow_pkg::FLAGS_ADDR, 8'h40, 1'b0}, flow_pkg::ALU_ADD, 16'h0F01, flow_pkg::FLOW_STEP, 17'h0, '0, 1'b0);
    chk(flags, 8'h5A);
    go({1'b1, flow_pkg::FLAGS_ADDR, 8'h00, 1'b1}, flow_pkg::ALU_NONE, 16'h0, flow_pkg::FLOW_STEP, 17'h0, '0, 1'b0);
    chk(flags, 8'h1E);
  endtask : t_write
  task automatic t_alu;
    alu(flow_pkg::ALU_ADD, 16'hFF01, 8'h00, 3'b111, 3'b000);
    alu(flow_pkg::ALU_ADD, 16'h0808, 8'h10, 3'b010, 3'b000);
    alu(flow_pkg::ALU_SUB, 16'h0505, 8'h00, 3'b111, 3'b000);
    alu(flow_pkg::ALU_SUB, 16'h1001, 8'h0F, 3'b001, 3'b000);
    alu(flow_pkg::ALU_SUB, 16'h0001, 8'hFF, 3'b000, 3'b000);
    alu(flow_pkg::ALU_ROT_LEFT, 16'h8100, 8'h02, 3'b001, 3'b110);
    alu(flow_pkg::ALU_ROT_RIGHT, 16'h0100, 8'h80, 3'b001, 3'b110);
  endtask : t_alu
  task automatic t_page;
    for (int p = 0; p < 4; p++) begin
      wr({1'b0, p[1:0], 5'h00});
      fl(flow_pkg::FLOW_JUMP, 9'h1AB, 8'h00);
      chk(pc, {p[1:0], 9'h1AB});
      go({1'b1, flow_pkg::PCL_ADDR, 8'h34, 1'b0}, flow_pkg::ALU_NONE, 16'h0, flow_pkg::FLOW_PCL_WRITE, 17'h0, '0, 1'b0);
      chk(pc, {p[1:0], 1'b0, 8'h34});
    end
    wr(8'h00);
    fl(flow_pkg::FLOW_JUMP, 9'h1FF, 8'h00);
    fl(flow_pkg::FLOW_STEP, 9'h000, 8'h00);
    chk(pc, 11'h201);
    chk(flags[6:5], 2'b00);
    fl(flow_pkg::FLOW_JUMP, 9'h005, 8'h00);
    chk(pc, 11'h005);
  endtask : t_page
  task automatic t_stack;
    fl(flow_pkg::FLOW_JUMP, 9'h100, 8'h00);
    fl(flow_pkg::FLOW_CALL, 9'h010, 8'h00);
    fl(flow_pkg::FLOW_CALL, 9'h020, 8'h00);
    fl(flow_pkg::FLOW_CALL, 9'h030, 8'h00);
    chk(pc, 11'h030);
    fl(flow_pkg::FLOW_RETURN, 9'h000, 8'h5A);
    chk(pc, 11'h022);
    chk(w, 8'h5A);
    for (int i = 0; i < 3; i++) begin
      fl(flow_pkg::FLOW_RETURN, 9'h000, 8'hA5);
      chk(pc, 11'h012);
    end
    wr(8'h60);
    fl(flow_pkg::FLOW_JUMP, 9'h1F0, 8'h00);
    fl(flow_pkg::FLOW_CALL, 9'h040, 8'h00);
    chk(pc, 11'h640);
    fl(flow_pkg::FLOW_RETURN, 9'h000, 8'h00);
    chk(pc, 11'h7F2);
    m.ins('0, flow_pkg::ALU_NONE, 16'h0000, flow_pkg::FLOW_CALL, {9'h050, 8'h00}, '0, 1'b0);
    m.ins('0, flow_pkg::ALU_NONE, 16'h0000, flow_pkg::FLOW_RETURN, {9'h000, 8'h3C}, '0, 1'b0);
    m.ins('0, flow_pkg::ALU_NONE, 16'h0000, flow_pkg::FLOW_STEP, 17'h00000, '0, 1'b0);
    #1;
    chk(pc, 11'h7F4);
    chk(w, 8'h3C);
  endtask : t_stack
  // ==========================================
  // run control
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #50000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    t_reset;
    t_write;
    t_alu;
    pw(3'b001, 2'b01);
    pw(3'b010, 2'b10);
    pw(3'b100, 2'b11);
    t_page;
    t_stack;
    finish_test;
  end
endmodule : tb_top
